/* File: sfd_host_model.sv */
// Behavioural serial host master that sends frames into the decoder
`timescale 1ns/1ps
`default_nettype none
module sfd_host_model (
  output logic sclk_out,
  output logic select_low_out,
  output logic mosi_out,
  input wire logic miso_in
);
  localparam realtime HALF = 62.5;
  initial begin
    sclk_out = 1'b0;
    select_low_out = 1'b1;
    mosi_out = 1'b0;
  end
  // Shifts nb bits from the top of v; r collects the bits seen on miso
  task automatic frame(input logic [63:0] v, input int nb, input logic variable_length_frames,
    output logic [63:0] r);
    r = 64'h0;
    if (variable_length_frames || select_low_out) begin
      select_low_out = 1'b1;
      #HALF;
      select_low_out = 1'b0;
      #HALF;
    end
    for (int i = 0; i < nb; i++) begin
      mosi_out = v[63-i];
      #HALF;
      sclk_out = 1'b1;
      r = {r[62:0], miso_in};
      #HALF;
      sclk_out = 1'b0;
    end
    #HALF;
    if (variable_length_frames) begin
      select_low_out = 1'b1;
      mosi_out = ~mosi_out;
      #HALF;
    end
  endtask
endmodule
`default_nettype wire

/* File: sfd_pkg.sv */
// Constants and types of the serial frame decoder
package sfd_pkg;
  localparam int SFD_ADDR_BITS = 16;
  localparam int SFD_SYNC_STAGES = 3;
  localparam logic [3:0] SFD_ADDR_LAST = 4'hF;
  localparam logic [3:0] SFD_BYTE_LAST = 4'h7;
  localparam logic [3:0] SFD_CNT_RST = 4'h0;
  localparam logic [2:0] SFD_BYTES_RST = 3'h0;
  localparam logic [15:0] SFD_ADDR_RST = 16'h0000;
  localparam logic [7:0] SFD_BYTE_RST = 8'h00;
  localparam logic [15:0] SFD_ADDR_STEP = 16'h0001;
  localparam int SFD_CTRL_SOCK_MSB = 7;
  localparam int SFD_CTRL_SOCK_LSB = 5;
  localparam int SFD_CTRL_SUB_MSB = 4;
  localparam int SFD_CTRL_SUB_LSB = 3;
  localparam int SFD_CTRL_DIR = 2;
  localparam int SFD_CTRL_MODE_MSB = 1;
  localparam int SFD_CTRL_MODE_LSB = 0;
  localparam logic [2:0] SFD_LAST_OF_1 = 3'h0;
  localparam logic [2:0] SFD_LAST_OF_2 = 3'h1;
  localparam logic [2:0] SFD_LAST_OF_4 = 3'h3;
  localparam logic [2:0] SFD_SOCKET0 = 3'h0;

  typedef enum logic [1:0] {
    SFD_ST_ADDR = 2'h0,
    SFD_ST_CTRL = 2'h1,
    SFD_ST_DATA = 2'h3
  } sfd_state_t;

  typedef enum logic [1:0] {
    SFD_SUB_COMMON = 2'h0,
    SFD_SUB_REGS = 2'h1,
    SFD_SUB_TXBUF = 2'h2,
    SFD_SUB_RXBUF = 2'h3
  } sfd_sub_t;

  typedef enum logic [1:0] {
    SFD_LEN_VAR = 2'h0,
    SFD_LEN_1 = 2'h1,
    SFD_LEN_2 = 2'h2,
    SFD_LEN_4 = 2'h3
  } sfd_len_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [2:0] socket;
    sfd_sub_t sub;
    logic write;
    logic [7:0] data;
  } sfd_access_t;

  localparam sfd_access_t SFD_ACCESS_RST = '{16'h0000, 3'h0, SFD_SUB_COMMON, 1'b0, 8'h00};
endpackage

/* File: sfd_spi_frame_decoder.sv */
// Serial frame decoder: address, control and data phases
// Summary of operation
// - Frame is address, control, then data
// - Address phase carries 16-bit offset
// - Offset shifted most significant bit first
// - Offset increments after every data byte
// - Control: block 7-3, direction 2, length 1-0
// - Socket number, subblock; 00 common on socket 0, else reserved
// - Data length 1, 2, 4 or unbounded
// - Select falling starts, rising ends frame
// - Variable mode data phase is unbounded
// - Fixed mode: select low, exact byte count
// - Direction 0 reads, 1 writes
// - Length 00 variable, 01/10/11 one/two/four
// - Sample on rising, change on falling clock
`timescale 1ns/1ps
`default_nettype none
module sfd_spi_frame_decoder import sfd_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic sclk_in,
  input wire logic select_low_in,
  input wire logic mosi_in,
  input wire logic [7:0] rd_data_in,
  output logic miso_out,
  output logic miso_oe_out,
  output sfd_access_t access_out,
  output logic wr_strobe_out,
  output logic rd_strobe_out,
  output logic frame_active_out,
  output logic reserved_block_out
);
  logic [2:0] s2;
  logic [2:0] s3;
  logic sclk_f, cs_f, mosi_f, sclk_prev, cs_prev;
  logic rise, fall, cs_rise;
  sfd_state_t state;
  logic [3:0] cnt;
  logic [15:0] addr_q;
  logic [7:0] ctrl_sh;
  logic [7:0] data_sh;
  logic [2:0] socket_q;
  sfd_sub_t sub_q;
  logic write_q;
  sfd_len_t len_q;
  logic [2:0] bytes;
  logic [2:0] last_byte;
  logic ok_q;
  logic load_pending;
  logic [7:0] rd_cap;
  logic [7:0] tx_sh;
  logic [7:0] ctrl_byte;
  logic ctrl_ok;
  logic byte_done;
  logic frame_last;

  sfd_sync #(.WIDTH(SFD_SYNC_STAGES)) u_sync (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .async_in({sclk_in, select_low_in, mosi_in}),
    .rst_val_in(3'h7),
    .stage2_out(s2),
    .stage3_out(s3)
  );

  // Filtered levels change once stages 2 and 3 agree
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sclk_f <= 1'b1;
      cs_f <= 1'b1;
      mosi_f <= 1'b1;
      sclk_prev <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      if (s2[2] == s3[2]) sclk_f <= s3[2];
      if (s2[1] == s3[1]) cs_f <= s3[1];
      if (s2[0] == s3[0]) mosi_f <= s3[0];
      sclk_prev <= sclk_f;
      cs_prev <= cs_f;
    end
  end

  assign rise = sclk_f & ~sclk_prev & ~cs_f;
  assign fall = ~sclk_f & sclk_prev & ~cs_f;
  assign cs_rise = cs_f & ~cs_prev;
  assign ctrl_byte = {ctrl_sh[6:0], mosi_f};
  assign ctrl_ok = !(ctrl_byte[SFD_CTRL_SUB_MSB:SFD_CTRL_SUB_LSB] == SFD_SUB_COMMON
    && ctrl_byte[SFD_CTRL_SOCK_MSB:SFD_CTRL_SOCK_LSB] != SFD_SOCKET0);
  assign byte_done = rise && state == SFD_ST_DATA && cnt == SFD_BYTE_LAST;
  assign frame_last = len_q != SFD_LEN_VAR && bytes == last_byte;

  always_comb begin
    case (len_q)
      SFD_LEN_1: last_byte = SFD_LAST_OF_1;
      SFD_LEN_2: last_byte = SFD_LAST_OF_2;
      SFD_LEN_4: last_byte = SFD_LAST_OF_4;
      default: last_byte = SFD_LAST_OF_4;
    endcase
  end

  // Phase sequencing
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= SFD_ST_ADDR;
      cnt <= SFD_CNT_RST;
      bytes <= SFD_BYTES_RST;
    end else if (cs_f) begin
      state <= SFD_ST_ADDR;
      cnt <= SFD_CNT_RST;
      bytes <= SFD_BYTES_RST;
    end else if (rise) begin
      cnt <= cnt + 4'h1;
      case (state)
        SFD_ST_ADDR: if (cnt == SFD_ADDR_LAST) begin
          state <= SFD_ST_CTRL;
          cnt <= SFD_CNT_RST;
        end
        SFD_ST_CTRL: if (cnt == SFD_BYTE_LAST) begin
          state <= SFD_ST_DATA;
          cnt <= SFD_CNT_RST;
          bytes <= SFD_BYTES_RST;
        end
        SFD_ST_DATA: if (cnt == SFD_BYTE_LAST) begin
          cnt <= SFD_CNT_RST;
          bytes <= bytes + 3'h1;
          if (frame_last) begin
            state <= SFD_ST_ADDR;
          end
        end
        default: begin
          state <= SFD_ST_ADDR;
          cnt <= SFD_CNT_RST;
        end
      endcase
    end
  end

  // Offset, control and data shift registers
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      addr_q <= SFD_ADDR_RST;
      ctrl_sh <= SFD_BYTE_RST;
      data_sh <= SFD_BYTE_RST;
      socket_q <= SFD_SOCKET0;
      sub_q <= SFD_SUB_COMMON;
      write_q <= 1'b0;
      len_q <= SFD_LEN_VAR;
      ok_q <= 1'b0;
    end else if (rise) begin
      case (state)
        SFD_ST_ADDR: addr_q <= {addr_q[14:0], mosi_f};
        SFD_ST_CTRL: begin
          ctrl_sh <= ctrl_byte;
          if (cnt == SFD_BYTE_LAST) begin
            socket_q <= ctrl_byte[SFD_CTRL_SOCK_MSB:SFD_CTRL_SOCK_LSB];
            sub_q <= sfd_sub_t'(ctrl_byte[SFD_CTRL_SUB_MSB:SFD_CTRL_SUB_LSB]);
            write_q <= ctrl_byte[SFD_CTRL_DIR];
            len_q <= sfd_len_t'(ctrl_byte[SFD_CTRL_MODE_MSB:SFD_CTRL_MODE_LSB]);
            ok_q <= ctrl_ok;
          end
        end
        SFD_ST_DATA: begin
          data_sh <= {data_sh[6:0], mosi_f};
          if (cnt == SFD_BYTE_LAST) addr_q <= addr_q + SFD_ADDR_STEP;
        end
        default: ctrl_sh <= SFD_BYTE_RST;
      endcase
    end
  end

  // Access strobes towards the register and buffer side
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      access_out <= SFD_ACCESS_RST;
      wr_strobe_out <= 1'b0;
      rd_strobe_out <= 1'b0;
      reserved_block_out <= 1'b0;
    end else begin
      wr_strobe_out <= 1'b0;
      rd_strobe_out <= 1'b0;
      if (rise && state == SFD_ST_CTRL && cnt == SFD_BYTE_LAST) begin
        reserved_block_out <= !ctrl_ok;
        access_out <= '{addr_q, ctrl_byte[SFD_CTRL_SOCK_MSB:SFD_CTRL_SOCK_LSB],
          sfd_sub_t'(ctrl_byte[SFD_CTRL_SUB_MSB:SFD_CTRL_SUB_LSB]),
          ctrl_byte[SFD_CTRL_DIR], SFD_BYTE_RST};
        rd_strobe_out <= ctrl_ok && !ctrl_byte[SFD_CTRL_DIR];
      end else if (byte_done && ok_q) begin
        if (write_q) begin
          access_out <= '{addr_q, socket_q, sub_q, 1'b1, {data_sh[6:0], mosi_f}};
          wr_strobe_out <= 1'b1;
        end else if (!frame_last) begin
          access_out <= '{addr_q + SFD_ADDR_STEP, socket_q, sub_q, 1'b0, SFD_BYTE_RST};
          rd_strobe_out <= 1'b1;
        end
      end
    end
  end

  // Read data goes out on falling clock edges
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      load_pending <= 1'b0;
      rd_cap <= SFD_BYTE_RST;
      tx_sh <= SFD_BYTE_RST;
      miso_out <= 1'b0;
    end else begin
      if (rd_strobe_out) begin
        load_pending <= 1'b1;
      end else if (cs_f) begin
        load_pending <= 1'b0;
      end else if (fall && load_pending) begin
        load_pending <= 1'b0;
      end
      if (rd_strobe_out) rd_cap <= rd_data_in;
      if (fall && state == SFD_ST_DATA && !write_q) begin
        if (load_pending && !rd_strobe_out) begin
          miso_out <= rd_cap[7];
          tx_sh <= {rd_cap[6:0], 1'b0};
        end else begin
          miso_out <= tx_sh[7];
          tx_sh <= {tx_sh[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      miso_oe_out <= 1'b0;
      frame_active_out <= 1'b0;
    end else begin
      miso_oe_out <= !cs_f && state == SFD_ST_DATA && !write_q && ok_q;
      frame_active_out <= !cs_f;
    end
  end

  sequence sfd_ctrl_end_s;
    rise && state == SFD_ST_CTRL && cnt == SFD_BYTE_LAST;
  endsequence

  sequence sfd_byte_end_s;
    rise && state == SFD_ST_DATA && cnt == SFD_BYTE_LAST;
  endsequence

  phase_order_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    rise && !cs_f && state == SFD_ST_ADDR && cnt == SFD_ADDR_LAST |=> state == SFD_ST_CTRL)
    else $error("address phase not followed by control phase");
  addr_shift_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    rise && !cs_f && state == SFD_ST_ADDR |=> addr_q[0] == $past(mosi_f)
      && addr_q[15:1] == $past(addr_q[14:0]))
    else $error("offset not shifted msb first");
  addr_inc_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    wr_strobe_out |-> addr_q == access_out.addr + SFD_ADDR_STEP)
    else $error("offset not incremented after byte");
  ctrl_field_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    sfd_ctrl_end_s ##1 !cs_f |-> socket_q == $past(ctrl_sh[6:4])
      && write_q == $past(ctrl_sh[1]) && len_q == $past({ctrl_sh[0], mosi_f}))
    else $error("control fields misplaced");
  reserved_blk_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    wr_strobe_out || rd_strobe_out |-> !(access_out.sub == SFD_SUB_COMMON
      && access_out.socket != SFD_SOCKET0))
    else $error("reserved block accessed");
  fixed_len_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    sfd_byte_end_s and (!cs_f && frame_last) |=> state == SFD_ST_ADDR && cnt == SFD_CNT_RST)
    else $error("fixed frame did not return to address phase");
  var_len_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    sfd_byte_end_s and (!cs_f && len_q == SFD_LEN_VAR) |=> state == SFD_ST_DATA)
    else $error("variable frame ended without select");
  frame_end_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    cs_rise |=> state == SFD_ST_ADDR && cnt == SFD_CNT_RST)
    else $error("select release did not end frame");
  read_dir_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    rd_strobe_out |-> !access_out.write && !write_q)
    else $error("read strobe on write access");
  miso_edge_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    $changed(miso_out) |-> $past(fall))
    else $error("output data changed off falling edge");
endmodule
`default_nettype wire

/* File: sfd_spi_frame_decoder_tb.sv */
// Self-checking bench for the serial frame decoder
`timescale 1ns/1ps
`default_nettype none
module sfd_spi_frame_decoder_tb import sfd_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] rd_data = 8'h00;
  logic sclk, select_low, mosi, miso, miso_oe, wr_stb, rd_stb, active, rsvd;
  wire logic miso_w;
  sfd_access_t acc;
  sfd_access_t wq[$];
  logic [15:0] rq[$];
  int n_fail = 0;
  int comparisons = 0;
  assign miso_w = miso_oe ? miso : ~miso;
  sfd_host_model host (.sclk_out(sclk), .select_low_out(select_low), .mosi_out(mosi),
    .miso_in(miso_w));
  sfd_spi_frame_decoder uut (.clk_sys_in(clk), .sys_rst_in(rst), .sclk_in(sclk),
    .select_low_in(select_low), .mosi_in(mosi), .rd_data_in(rd_data), .miso_out(miso),
    .miso_oe_out(miso_oe), .access_out(acc), .wr_strobe_out(wr_stb), .rd_strobe_out(rd_stb),
    .frame_active_out(active), .reserved_block_out(rsvd));
  always #5 clk = ~clk;
  // Register side answers each read with a value tied to its offset
  always @(negedge clk) rd_data <= acc.addr[7:0] ^ 8'h5A;
  always @(posedge clk) begin
    if (wr_stb === 1'b1) wq.push_back(acc);
    if (rd_stb === 1'b1) rq.push_back(acc.addr);
  end
  task automatic close_out();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_wr(input sfd_access_t exp);
    sfd_access_t got;
    if (wq.size() > 0) got = wq.pop_front();
    else got = SFD_ACCESS_RST;
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch write access expected %h seen %h", exp, got);
    end
  endtask
  function automatic sfd_access_t mk(input logic [15:0] a, input logic [2:0] s,
    input sfd_sub_t b, input logic [7:0] d);
    mk = '{a, s, b, 1'b1, d};
  endfunction
  task automatic send(input logic [15:0] a, input logic [7:0] c, input logic [31:0] d,
    input int nb, input logic variable_length_frames, output logic [63:0] r);
    host.frame({a, c, d, 8'h00}, nb, variable_length_frames, r);
    repeat (10) @(negedge clk);
  endtask
  initial begin
    #300000;
    n_fail++;
    close_out();
  end
  initial begin
    logic [63:0] r;
    logic [23:0] dv;
    dv = 24'hA1B2C3;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    send(16'h1234, 8'h4D, 32'hC3000000, 32, 1'b0, r);
    chk("wr count", 1, wq.size());
    chk_wr(mk(16'h1234, 3'h2, SFD_SUB_REGS, 8'hC3));
    chk("frame active", 1, {31'h0, active});
    $display("test fixed_write done");
    send(16'h00FE, 8'hF7, 32'h11223344, 56, 1'b0, r);
    send(16'h0010, 8'h05, 32'h99000000, 32, 1'b0, r);
    chk("wr count", 5, wq.size());
    for (int i = 0; i < 4; i++) begin
      chk_wr(mk(16'(16'h00FE + i), 3'h7, SFD_SUB_TXBUF, 8'(8'h11 * (i + 1))));
    end
    chk_wr(mk(16'h0010, 3'h0, SFD_SUB_COMMON, 8'h99));
    $display("test fixed_burst done");
    send(16'h0040, 8'h1A, 32'h0, 40, 1'b0, r);
    chk("read data", 32'h00001A1B, {16'h0000, r[15:0]});
    chk("rd count", 2, rq.size());
    chk("rd addr", 32'h0040, {16'h0000, rq[0]});
    chk("rd addr", 32'h0041, {16'h0000, rq[1]});
    chk("wr count", 0, wq.size());
    $display("test fixed_read done");
    send(16'h0080, 8'h18, 32'h0, 40, 1'b1, r);
    chk("read data", 32'h0000DADB, {16'h0000, r[15:0]});
    chk("rd count", 5, rq.size());
    chk("rd addr", 32'h0080, {16'h0000, rq[2]});
    chk("rd addr", 32'h0082, {16'h0000, rq[4]});
    chk("wr count", 0, wq.size());
    $display("test variable_read done");
    send(16'hFFFF, 8'h6C, 32'hA1B2C300, 48, 1'b1, r);
    chk("frame active", 0, {31'h0, active});
    chk("wr count", 3, wq.size());
    for (int i = 0; i < 3; i++) begin
      chk_wr(mk(16'(16'hFFFF + i), 3'h3, SFD_SUB_REGS, dv[23-8*i -: 8]));
    end
    $display("test variable_write done");
    send(16'h0005, 8'h24, 32'h5A000000, 32, 1'b1, r);
    chk("reserved", 1, {31'h0, rsvd});
    chk("wr count", 0, wq.size());
    $display("test reserved done");
    send(16'h0200, 8'h6C, 32'hA5F00000, 36, 1'b1, r);
    chk("reserved", 0, {31'h0, rsvd});
    chk("wr count", 1, wq.size());
    chk_wr(mk(16'h0200, 3'h3, SFD_SUB_REGS, 8'hA5));
    $display("test abort done");
    close_out();
  end
endmodule
`default_nettype wire

/* File: sfd_sync.sv */
// Three-stage input synchroniser
`timescale 1ns/1ps
`default_nettype none
module sfd_sync import sfd_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] rst_val_in,
  output logic [WIDTH-1:0] stage2_out,
  output logic [WIDTH-1:0] stage3_out
);
  logic [WIDTH-1:0] stage1;

  // Stage 1 feeds stage 2 only
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stage1 <= '1;
      stage2_out <= '1;
      stage3_out <= '1;
    end else begin
      stage1 <= async_in;
      stage2_out <= stage1;
      stage3_out <= stage2_out;
    end
  end
endmodule
`default_nettype wire
